/* hdl/ipr_defines.svh */
// Purpose: Offsets, field positions, reset values and masks for the priority registers.
// Assumes: Register index equals offset; 16-bit registers.
// Notes: Definitions only.
`ifndef IPR_DEFINES_SVH
`define IPR_DEFINES_SVH

`define IPR_ADDR_W 3
`define IPR_NUM_REGS 6
`define IPR_OFS_CTRL0 3'h0
`define IPR_OFS_CTRL1 3'h1
`define IPR_OFS_CTRL2 3'h2
`define IPR_OFS_CTRL3 3'h3
`define IPR_OFS_CTRL4 3'h4
`define IPR_OFS_CTRL5 3'h5
`define IPR_FLD_POS3 12
`define IPR_FLD_POS2 8
`define IPR_FLD_POS1 4
`define IPR_FLD_POS0 0
`define IPR_FLD_RESET 3'h4
`define IPR_LEVEL_OFF 3'h0
`define IPR_MASK_FULL 16'h7777
`define IPR_MASK_CTRL3 16'h0777
`define IPR_MASK_CTRL4 16'h7077
`define IPR_RESET_FULL 16'h4444
`define IPR_RESET_CTRL3 16'h0444
`define IPR_RESET_CTRL4 16'h4044

`endif

/* hdl/ipr_pkg.sv */
// Purpose: Types shared by the priority register block.
// Assumes: Defines header is included by the user.
// Notes: Types only.
package ipr_pkg;

    typedef logic [2:0] ipr_level_t;

    typedef struct packed {
        logic [2:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } ipr_bus_req_t;

    typedef struct packed {
        ipr_level_t timer1_priority;
        ipr_level_t outcmp1_priority;
        ipr_level_t incap1_priority;
        ipr_level_t ext_irq0_priority;
        ipr_level_t timer2_priority;
        ipr_level_t outcmp2_priority;
        ipr_level_t incap2_priority;
        ipr_level_t dma_ch0_done_priority;
        ipr_level_t uart1_rx_priority;
        ipr_level_t spi1_event_priority;
        ipr_level_t spi1_error_priority;
        ipr_level_t timer3_priority;
        ipr_level_t dma_ch1_done_priority;
        ipr_level_t adc1_done_priority;
        ipr_level_t uart1_tx_priority;
        ipr_level_t change_notify_priority;
        ipr_level_t i2c1_master_priority;
        ipr_level_t i2c1_slave_priority;
        ipr_level_t incap8_priority;
        ipr_level_t incap7_priority;
        ipr_level_t adc2_done_priority;
        ipr_level_t ext_irq1_priority;
    } ipr_levels_t;

endpackage : ipr_pkg

/* hdl/ipr_priority_regs.sv */
// Purpose: Six interrupt priority control registers with priority and gated request outputs.
// Assumes: Single clock; bus strobes come from logic on the same clock.
// Notes: Read data is registered and valid only in the cycle after the read strobe.
//
// Function
// - Three-bit field; code seven is level seven, one is level one.
// - A zero field disables its source; request never reaches the processor.
// - Fields are read/write and reset to binary 100, level four.
// - Unimplemented bits, including 15, 11, 7, 3, read zero, ignore writes.
// - Register 0: timer1, outcmp1, incap1, ext_irq0 at 14-12, 10-8, 6-4, 2-0.
// - Register 1: timer2, outcmp2, incap2, dma_ch0 at 14-12, 10-8, 6-4, 2-0.
// - Register 2: uart1_rx, spi1 event, spi1 error, timer3 in the four fields.
// - Register 3: dma_ch1 10-8, adc1 6-4, uart1_tx 2-0; bits 15-11 unused.
// - Register 4: change notify 14-12, i2c1 master 6-4, slave 2-0; 11-7 unused.
// - Register 5: incap8, incap7, adc2, ext_irq1 in the four fields.
//
// Decided for this implementation: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
`include "ipr_defines.svh"

module ipr_priority_regs (
    // Clock and reset
    input wire logic clock,
    input wire logic rstn,
    // Register port
    input wire logic [2:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    // Interrupt sources, one request per field, same clock
    input wire logic [21:0] src_req,
    // Toward arbitration
    output ipr_pkg::ipr_levels_t levels,
    output logic [21:0] req_gated
);

    // ------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------
    logic rst_meta_r;
    logic rst_sync_r;

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            rst_meta_r <= 1'b0;
            rst_sync_r <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_sync_r <= rst_meta_r;
        end
    end

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [15:0] impl_mask(input logic [2:0] idx);
        case (idx)
            `IPR_OFS_CTRL3: impl_mask = `IPR_MASK_CTRL3;
            `IPR_OFS_CTRL4: impl_mask = `IPR_MASK_CTRL4;
            default: impl_mask = `IPR_MASK_FULL;
        endcase
    endfunction : impl_mask

    // Field k of a register word; k counts from the low field.
    function automatic logic [2:0] fld(input logic [15:0] w, input int k);
        fld = w[4*k +: 3];
    endfunction : fld

    // ------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------
    logic [15:0] ctrl_r [`IPR_NUM_REGS];
    logic [15:0] rdata_r;
    logic [15:0] rdata_nxt;
    logic [21:0] gated_r;
    logic [21:0] gated_nxt;
    ipr_pkg::ipr_levels_t levels_r;
    ipr_pkg::ipr_levels_t levels_nxt;

    // Reset loads level four in every implemented field; masking keeps separators at zero.
    always_ff @(posedge clock or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            // Plain constants here, so the reset branch never depends on a decode.
            ctrl_r[0] <= `IPR_RESET_FULL;
            ctrl_r[1] <= `IPR_RESET_FULL;
            ctrl_r[2] <= `IPR_RESET_FULL;
            ctrl_r[3] <= `IPR_RESET_CTRL3;
            ctrl_r[4] <= `IPR_RESET_CTRL4;
            ctrl_r[5] <= `IPR_RESET_FULL;
        end else if (reg_wr && (reg_addr < 3'(`IPR_NUM_REGS))) begin
            ctrl_r[reg_addr] <= reg_wdata & impl_mask(reg_addr);
        end
    end

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    // Unmapped addresses read zero so software probing past the map sees nothing.
    always_comb begin
        rdata_nxt = 16'h0000;
        if (reg_rd && (reg_addr < 3'(`IPR_NUM_REGS))) begin
            rdata_nxt = ctrl_r[reg_addr] & impl_mask(reg_addr);
        end
    end

    always_ff @(posedge clock or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            rdata_r <= 16'h0000;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    // ------------------------------------------------------------
    // Field map toward arbitration
    // ------------------------------------------------------------
    always_comb begin
        levels_nxt.timer1_priority = fld(ctrl_r[0], 3);
        levels_nxt.outcmp1_priority = fld(ctrl_r[0], 2);
        levels_nxt.incap1_priority = fld(ctrl_r[0], 1);
        levels_nxt.ext_irq0_priority = fld(ctrl_r[0], 0);
        levels_nxt.timer2_priority = fld(ctrl_r[1], 3);
        levels_nxt.outcmp2_priority = fld(ctrl_r[1], 2);
        levels_nxt.incap2_priority = fld(ctrl_r[1], 1);
        levels_nxt.dma_ch0_done_priority = fld(ctrl_r[1], 0);
        levels_nxt.uart1_rx_priority = fld(ctrl_r[2], 3);
        levels_nxt.spi1_event_priority = fld(ctrl_r[2], 2);
        levels_nxt.spi1_error_priority = fld(ctrl_r[2], 1);
        levels_nxt.timer3_priority = fld(ctrl_r[2], 0);
        levels_nxt.dma_ch1_done_priority = fld(ctrl_r[3], 2);
        levels_nxt.adc1_done_priority = fld(ctrl_r[3], 1);
        levels_nxt.uart1_tx_priority = fld(ctrl_r[3], 0);
        levels_nxt.change_notify_priority = fld(ctrl_r[4], 3);
        levels_nxt.i2c1_master_priority = fld(ctrl_r[4], 1);
        levels_nxt.i2c1_slave_priority = fld(ctrl_r[4], 0);
        levels_nxt.incap8_priority = fld(ctrl_r[5], 3);
        levels_nxt.incap7_priority = fld(ctrl_r[5], 2);
        levels_nxt.adc2_done_priority = fld(ctrl_r[5], 1);
        levels_nxt.ext_irq1_priority = fld(ctrl_r[5], 0);
    end

    // A source whose level is zero never passes its request on.
    always_comb begin
        logic [65:0] flat;
        flat = levels_nxt;
        gated_nxt = '0;
        for (int s = 0; s < 22; s++) begin
            gated_nxt[s] = src_req[s] && (flat[3*s +: 3] != `IPR_LEVEL_OFF);
        end
    end

    // Outputs are registered, so arbitration sees a write one cycle after it lands.
    always_ff @(posedge clock or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            levels_r <= '0;
            gated_r <= '0;
        end else begin
            levels_r <= levels_nxt;
            gated_r <= gated_nxt;
        end
    end

    assign reg_rdata = rdata_r;
    assign levels = levels_r;
    assign req_gated = gated_r;

endmodule : ipr_priority_regs

/* verif/ipr_regs_props.sv */
// Purpose: Port checks for the priority register block.
// Assumes: One clock; read data stands one cycle after the strobe.
// Notes: Bound to every instance of the register block.
`timescale 1ns/1ps
module ipr_regs_props (
    // Clock and reset
    input wire logic clock,
    input wire logic rstn,
    // Register port
    input wire logic [2:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_rdata,
    // Requests and levels
    input wire logic [21:0] src_req,
    input wire ipr_pkg::ipr_levels_t levels,
    input wire logic [21:0] req_gated
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);
    a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 16'h0000) else $error("read data not idle");
    a_gap_bits: assert property (reg_rd |=> (reg_rdata & 16'h8888) == 16'h0000) else $error("gap bit set");
    a_reg3_high: assert property (reg_rd && reg_addr == 3'h3 |=> reg_rdata[15:11] == 5'h00) else $error("reg3 high");
    a_reg4_mid: assert property (reg_rd && reg_addr == 3'h4 |=> reg_rdata[11:7] == 5'h00) else $error("reg4 mid");
    a_bad_addr: assert property (reg_rd && reg_addr > 3'h5 |=> reg_rdata == 16'h0000) else $error("bad addr read");
    a_wr_rd: assert property (reg_wr && reg_addr == 3'h1 ##1 reg_rd && reg_addr == 3'h1 |=>
        reg_rdata == ($past(reg_wdata, 2) & 16'h7777)) else $error("readback differs");
    a_level_wr: assert property (reg_wr && reg_addr == 3'h0 |=> ##1
        {1'b0, levels.timer1_priority, 12'h000} == ($past(reg_wdata, 2) & 16'h7000)) else $error("level late");
    a_gate_off: assert property (levels.ext_irq1_priority == 3'h0 && $past(levels.ext_irq1_priority) == 3'h0
        |-> !req_gated[0]) else $error("disabled request passed");
    a_gate_src: assert property (req_gated[21] |-> $past(src_req[21])) else $error("request without source");
endmodule : ipr_regs_props
bind ipr_priority_regs ipr_regs_props props_u (.clock(clock), .rstn(rstn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .src_req(src_req),
    .levels(levels), .req_gated(req_gated));

/* verif/ipr_src_model.sv */
// Purpose: Stand-in for the interrupt sources.
// Assumes: Requests are levels on the block clock.
// Notes: Lines stay low in reset so nothing is pending at start.
`timescale 1ns/1ps
module ipr_src_model (
    // Clock and reset
    input wire logic clock,
    input wire logic rstn,
    // Pattern in, requests out
    input wire logic [21:0] pattern,
    output logic [21:0] src_req
);
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            src_req <= 22'h00_0000;
        end else begin
            src_req <= pattern;
        end
    end
endmodule : ipr_src_model

/* verif/testbench.sv */
// Purpose: Register and level checks for the priority block.
// Assumes: Field table below marks implemented fields per register.
// Notes: Gating expectation is rebuilt from the written words.
`timescale 1ns/1ps
module testbench;
    logic clock = 1'b0;
    logic rstn = 1'b0;
    logic [2:0] reg_addr = 3'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [15:0] reg_rdata;
    logic [21:0] pattern = 22'h3F_FFFF;
    logic [21:0] src_req;
    logic [21:0] req_gated;
    logic [21:0] gate_exp;
    logic [65:0] lv_exp;
    ipr_pkg::ipr_levels_t levels;
    logic [15:0] w [6] = '{16'h1234, 16'h5670, 16'h7012, 16'h0345, 16'h6071, 16'h2310};
    logic [15:0] msk [6] = '{16'h7777, 16'h7777, 16'h7777, 16'h0777, 16'h7077, 16'h7777};
    int s;
    int n_errors = 0;
    int checks_done = 0;
    always #12.5 clock = ~clock;
    ipr_src_model src_u (.clock(clock), .rstn(rstn), .pattern(pattern), .src_req(src_req));
    ipr_priority_regs dut_u (.clock(clock), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .src_req(src_req), .levels(levels),
        .req_gated(req_gated));
    task automatic chk(input string nm, input logic [65:0] seen, input logic [65:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic wr(input logic [2:0] a, input logic [15:0] d);
        @(posedge clock);
        reg_rd <= 1'b0;
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
    endtask : wr
    task automatic rd(input logic [2:0] a, input logic [15:0] exp);
        @(posedge clock);
        reg_wr <= 1'b0;
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1 chk("reg_rdata", 66'(reg_rdata), 66'(exp));
    endtask : rd
    task automatic chk_out;
        for (int i = 0; i < 22; i++) begin
            gate_exp[i] = pattern[i] & (lv_exp[3*i +: 3] != 3'h0);
        end
        chk("levels", 66'(levels), lv_exp);
        chk("req_gated", 66'(req_gated), 66'(gate_exp));
    endtask : chk_out
    task automatic end_sim;
        if (n_errors == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : end_sim
    initial begin
        repeat (8) @(posedge clock);
        rstn <= 1'b1;
        repeat (3) @(posedge clock);
        lv_exp = {22{3'h4}};
        #1 chk_out();
        for (int k = 0; k < 6; k++) begin
            rd(3'(k), msk[k] & 16'h4444);
        end
        for (int k = 0; k < 8; k++) begin
            wr(3'(k), 16'hFFFF);
            rd(3'(k), (k < 6) ? msk[k] : 16'h0000);
        end
        s = 22;
        for (int k = 0; k < 6; k++) begin
            wr(3'(k), w[k]);
            for (int p = 12; p >= 0; p -= 4) begin
                if (msk[k][p +: 3] != 3'h0) begin
                    s--;
                    lv_exp[3*s +: 3] = w[k][p +: 3];
                end
            end
        end
        rd(3'h5, w[5] & msk[5]);
        @(posedge clock);
        #1 chk_out();
        @(posedge clock);
        pattern <= 22'h2A_AAAA;
        repeat (3) @(posedge clock);
        #1 chk_out();
        // A reset in mid-run must reload every field with level four.
        @(posedge clock);
        rstn <= 1'b0;
        @(posedge clock);
        rstn <= 1'b1;
        repeat (3) @(posedge clock);
        lv_exp = {22{3'h4}};
        #1 chk_out();
        rd(3'h4, 16'h4044);
        end_sim();
    end
    initial begin
        #50000;
        n_errors++;
        end_sim();
    end
endmodule : testbench
